// ### rtl/ima_pkg.sv
// package: constants, kinds and state type for the indirect data memory access block
package ima_pkg;

  // ****************************************************************
  // sector 0 layout of the ports and pointers
  // ****************************************************************
  localparam logic [7:0] IMA_OFS_PORT0  = 8'h00; // indirect_port_zero
  localparam logic [7:0] IMA_OFS_PTR0   = 8'h01; // pointer_zero
  localparam logic [7:0] IMA_OFS_PORT1  = 8'h02; // indirect_port_one
  localparam logic [7:0] IMA_OFS_PTR1L  = 8'h03; // pointer_one_low
  localparam logic [7:0] IMA_OFS_PTR1H  = 8'h04; // pointer_one_sector
  localparam logic [7:0] IMA_OFS_PORT2  = 8'h0c; // indirect_port_two
  localparam logic [7:0] IMA_OFS_PTR2L  = 8'h0d; // pointer_two_low
  localparam logic [7:0] IMA_OFS_PTR2H  = 8'h0e; // pointer_two_sector
  localparam logic [7:0] IMA_SECT_ZERO  = 8'h00;
  localparam logic [7:0] IMA_SECT_ONE   = 8'h01;
  localparam int         IMA_GPR_BIT    = 7;     // offs bit 7 set selects general RAM
  localparam logic [7:0] IMA_PTR_RST    = 8'h00; // pointer reset value
  localparam logic [7:0] IMA_ZERO_DATA  = 8'h00; // read value of unused and port targets
  localparam int         IMA_NUM_SECT   = 16;

  // ****************************************************************
  // special-purpose area masks, bit n covers offset n
  // ****************************************************************
  localparam logic [127:0] IMA_UNUSED_S0 = 128'h40000004_01c6f000_0100ff80_00000000;
  localparam logic [127:0] IMA_UNUSED_S1 = 128'hffffffff_fc000000_00000000_00000000;
  localparam logic [127:0] IMA_RSVD_S0   = 128'h0;
  localparam logic [127:0] IMA_RSVD_S1   = 128'h0;
  localparam logic [127:0] IMA_PROT_S0   = 128'h0;
  localparam logic [127:0] IMA_PROT_S1   = 128'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    IMA_K_PORT0, IMA_K_PORT1, IMA_K_PORT2, IMA_K_PTR, IMA_K_SFR,
    IMA_K_PROT, IMA_K_RSVD, IMA_K_UNUSED, IMA_K_RAM
  } ima_kind_e;

  typedef enum logic [1:0] {IMA_IDLE, IMA_ISSUE, IMA_DONE} ima_st_e;

  typedef struct packed {
    ima_st_e   st;
    logic [7:0] ptr0;
    logic [7:0] ptr1_lo;
    logic [7:0] ptr1_sect;
    logic [7:0] ptr2_lo;
    logic [7:0] ptr2_sect;
    ima_kind_e kind;
    logic      we;
    logic [7:0] sect;
    logic [7:0] offs;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic      ack;
  } ima_state_s;

  // true for any of the three indirect ports
  function automatic logic ima_is_port(input ima_kind_e k);
    ima_is_port = (k == IMA_K_PORT0) || (k == IMA_K_PORT1) || (k == IMA_K_PORT2);
  endfunction : ima_is_port

endpackage : ima_pkg

// ### rtl/ima_dec_if.sv
// interface: one address to classify and its kind
`timescale 1ns/1ps
`default_nettype none
interface ima_dec_if;
  import ima_pkg::*;
  logic [7:0] sect;
  logic [7:0] offs;
  ima_kind_e  kind;
  modport req (output sect, output offs, input kind);
  modport dec (input sect, input offs, output kind);
endinterface : ima_dec_if
`default_nettype wire

// ### rtl/ima_decode.sv
// module: classifies a sector/offset pair in the data memory map
`timescale 1ns/1ps
`default_nettype none
module ima_decode
  import ima_pkg::*;
#(
  parameter int NUM_SECT = IMA_NUM_SECT
) (
  ima_dec_if.dec dif
);

  // mask lookup for the special-purpose area of sectors 0 and 1
  function automatic ima_kind_e mask_kind(input logic [127:0] un, input logic [127:0] rs,
                                          input logic [127:0] pr, input logic [6:0] idx);
    if (un[idx])
      mask_kind = IMA_K_UNUSED;
    else if (rs[idx])
      mask_kind = IMA_K_RSVD;
    else if (pr[idx])
      mask_kind = IMA_K_PROT;
    else
      mask_kind = IMA_K_SFR;
  endfunction : mask_kind

  // ****************************************************************
  // decode
  // ****************************************************************
  // sectors above 1 carry no special-purpose registers, so their low half reads as unused
  always_comb
  begin
    dif.kind = IMA_K_UNUSED;
    if (32'(dif.sect) >= NUM_SECT)
      dif.kind = IMA_K_UNUSED;
    else if (dif.offs[IMA_GPR_BIT])
      dif.kind = IMA_K_RAM;
    else if (dif.sect == IMA_SECT_ZERO)
    begin
      case (dif.offs)
        IMA_OFS_PORT0: dif.kind = IMA_K_PORT0;
        IMA_OFS_PORT1: dif.kind = IMA_K_PORT1;
        IMA_OFS_PORT2: dif.kind = IMA_K_PORT2;
        IMA_OFS_PTR0, IMA_OFS_PTR1L, IMA_OFS_PTR1H,
        IMA_OFS_PTR2L, IMA_OFS_PTR2H: dif.kind = IMA_K_PTR;
        default: dif.kind = mask_kind(IMA_UNUSED_S0, IMA_RSVD_S0, IMA_PROT_S0,
                                      dif.offs[6:0]);
      endcase
    end
    else if (dif.sect == IMA_SECT_ONE)
      dif.kind = mask_kind(IMA_UNUSED_S1, IMA_RSVD_S1, IMA_PROT_S1, dif.offs[6:0]);
  end

endmodule : ima_decode
`default_nettype wire

// ### rtl/ima_indirect_top.sv
// module: indirect port resolution, memory pointers and data memory access sequencing
//
// How it works
// - A read of an unused special-purpose location answers 00H.
// - A protected register can be read but a write to it never reaches it.
// - A reserved location passes reads but no write ever reaches it.
// - An access to an indirect port acts on the location its pointer names, not the port.
// - Port zero reaches only sector 0, at the offset held in pointer_zero.
// - Ports one and two reach any sector through their two-byte pointers.
// - A resolved target that is itself a port reads as 00H.
// - A write whose resolved target is a port changes nothing.
// - The sector byte of a pointer pair picks the sector, the low byte the offset.
// - Offsets 00H-7FH are the special-purpose area, 80H-FFH general RAM.
`timescale 1ns/1ps
`default_nettype none
module ima_indirect_top
  import ima_pkg::*;
#(
  parameter int NUM_SECT = IMA_NUM_SECT,
  parameter int SW       = $clog2(NUM_SECT),
  parameter int AW       = SW + 8
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          cpu_req,
  input  wire logic          cpu_we,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [7:0]    cpu_wdata,
  output logic               cpu_ready,
  output logic               cpu_ack,
  output logic [7:0]         cpu_rdata,
  output logic               ram_req,
  output logic               ram_we,
  output logic [AW-2:0]      ram_addr,
  output logic [7:0]         ram_wdata,
  input  wire logic [7:0]    ram_rdata,
  output logic               sfr_req,
  output logic               sfr_we,
  output logic [AW-1:0]      sfr_addr,
  output logic [7:0]         sfr_wdata,
  input  wire logic [7:0]    sfr_rdata
);

  ima_state_s r;
  ima_state_s r_nxt;
  logic [7:0] res_sect;
  logic [7:0] res_offs;
  logic       take;

  ima_dec_if dir_if ();
  ima_dec_if res_if ();

  // ****************************************************************
  // address classification
  // ****************************************************************
  // the direct address is classified first, then the address it resolves to
  assign dir_if.sect = 8'(cpu_addr[AW-1:8]);
  assign dir_if.offs = cpu_addr[7:0];
  assign res_if.sect = res_sect;
  assign res_if.offs = res_offs;

  ima_decode #(.NUM_SECT(NUM_SECT)) u_dir_dec (.dif(dir_if));
  ima_decode #(.NUM_SECT(NUM_SECT)) u_res_dec (.dif(res_if));

  // port resolution through the pointers; one level only, a port target is not chased
  always_comb
  begin
    res_sect = dir_if.sect;
    res_offs = dir_if.offs;
    case (dir_if.kind)
      IMA_K_PORT0:
      begin
        res_sect = IMA_SECT_ZERO;
        res_offs = r.ptr0;
      end
      IMA_K_PORT1:
      begin
        res_sect = r.ptr1_sect;
        res_offs = r.ptr1_lo;
      end
      IMA_K_PORT2:
      begin
        res_sect = r.ptr2_sect;
        res_offs = r.ptr2_lo;
      end
      default:
      begin
        res_sect = dir_if.sect;
        res_offs = dir_if.offs;
      end
    endcase
  end

  // pointer read mux, shared by the read path
  function automatic logic [7:0] ptr_read(input ima_state_s s);
    case (s.offs)
      IMA_OFS_PTR0:  ptr_read = s.ptr0;
      IMA_OFS_PTR1L: ptr_read = s.ptr1_lo;
      IMA_OFS_PTR1H: ptr_read = s.ptr1_sect;
      IMA_OFS_PTR2L: ptr_read = s.ptr2_lo;
      IMA_OFS_PTR2H: ptr_read = s.ptr2_sect;
      default:       ptr_read = IMA_ZERO_DATA;
    endcase
  endfunction : ptr_read

  // ****************************************************************
  // sequencer and pointer registers
  // ****************************************************************
  assign take = cpu_req && (r.st == IMA_IDLE);

  // one request at a time: capture, issue for one cycle, then answer
  always_comb
  begin
    r_nxt = r;
    r_nxt.ack = 1'b0;
    case (r.st)
      IMA_IDLE:
      begin
        if (cpu_req)
        begin
          r_nxt.kind  = res_if.kind;
          r_nxt.sect  = res_sect;
          r_nxt.offs  = res_offs;
          r_nxt.we    = cpu_we;
          r_nxt.wdata = cpu_wdata;
          r_nxt.st    = IMA_ISSUE;
        end
      end
      IMA_ISSUE:
      begin
        case (r.kind)
          IMA_K_RAM:                       r_nxt.rdata = ram_rdata;
          IMA_K_SFR, IMA_K_PROT, IMA_K_RSVD: r_nxt.rdata = sfr_rdata;
          IMA_K_PTR:                       r_nxt.rdata = ptr_read(r);
          default:                         r_nxt.rdata = IMA_ZERO_DATA;
        endcase
        if (r.we && (r.kind == IMA_K_PTR))
        begin
          // pointers take any data write, so increment/decrement work as read-modify-write
          case (r.offs)
            IMA_OFS_PTR0:  r_nxt.ptr0      = r.wdata;
            IMA_OFS_PTR1L: r_nxt.ptr1_lo   = r.wdata;
            IMA_OFS_PTR1H: r_nxt.ptr1_sect = r.wdata;
            IMA_OFS_PTR2L: r_nxt.ptr2_lo   = r.wdata;
            IMA_OFS_PTR2H: r_nxt.ptr2_sect = r.wdata;
            default:       r_nxt.ptr0      = r.ptr0;
          endcase
        end
        r_nxt.ack = 1'b1;
        r_nxt.st  = IMA_DONE;
      end
      IMA_DONE:
        r_nxt.st = IMA_IDLE;
      default:
        r_nxt.st = IMA_IDLE;
    endcase
  end

  // state register; ce low freezes everything
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r       <= '0;
      r.st    <= IMA_IDLE;
      r.kind  <= IMA_K_UNUSED;
      r.ptr0      <= IMA_PTR_RST;
      r.ptr1_lo   <= IMA_PTR_RST;
      r.ptr1_sect <= IMA_PTR_RST;
      r.ptr2_lo   <= IMA_PTR_RST;
      r.ptr2_sect <= IMA_PTR_RST;
      r.rdata <= IMA_ZERO_DATA;
    end
    else if (ce)
      r <= r_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // port targets, unused space and pointers never reach the outside buses
  assign cpu_ready = (r.st == IMA_IDLE);
  assign cpu_ack   = r.ack;
  assign cpu_rdata = r.rdata;
  assign ram_req   = (r.st == IMA_ISSUE) && (r.kind == IMA_K_RAM);
  assign ram_we    = ram_req && r.we;
  assign ram_addr  = {r.sect[SW-1:0], r.offs[6:0]};
  assign ram_wdata = r.wdata;
  assign sfr_req   = (r.st == IMA_ISSUE) &&
                     ((r.kind == IMA_K_SFR) || (r.kind == IMA_K_PROT) || (r.kind == IMA_K_RSVD));
  assign sfr_we    = (r.st == IMA_ISSUE) && (r.kind == IMA_K_SFR) && r.we;
  assign sfr_addr  = {r.sect[SW-1:0], r.offs};
  assign sfr_wdata = r.wdata;

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [39:0]  ptrs;
  logic [127:0] locked_mask;
  assign ptrs = {r.ptr0, r.ptr1_lo, r.ptr1_sect, r.ptr2_lo, r.ptr2_sect};
  // reserved and protected offsets of the sector in issue, taken straight from the masks
  assign locked_mask = (r.sect == IMA_SECT_ZERO) ? (IMA_RSVD_S0 | IMA_PROT_S0) :
                                                   (IMA_RSVD_S1 | IMA_PROT_S1);

  property p_unused_zero;
    @(posedge clk) disable iff (!rstn || !ce)
    take && !cpu_we && (dir_if.kind == IMA_K_UNUSED) |-> ##2 cpu_ack && (cpu_rdata == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused read not zero");

  property p_prot_no_write;
    @(posedge clk) disable iff (!rstn || !ce)
    take && (res_if.kind == IMA_K_PROT) |=> sfr_req && !sfr_we;
  endproperty
  a_prot_no_write: assert property (p_prot_no_write) else $error("protected write leaked");

  property p_rsvd_no_write;
    @(posedge clk) disable iff (!rstn || !ce)
    take && (res_if.kind == IMA_K_RSVD) |=> !sfr_we && !ram_req;
  endproperty
  a_rsvd_no_write: assert property (p_rsvd_no_write) else $error("reserved write leaked");

  property p_port2_resolve;
    @(posedge clk) disable iff (!rstn || !ce)
    take && (dir_if.kind == IMA_K_PORT2) && (res_if.kind == IMA_K_RAM) |->
      ##1 ram_req && (ram_addr == {$past(r.ptr2_sect[SW-1:0]), $past(r.ptr2_lo[6:0])});
  endproperty
  a_port2_resolve: assert property (p_port2_resolve) else $error("port two misrouted");

  property p_port0_sector0;
    @(posedge clk) disable iff (!rstn || !ce)
    take && (dir_if.kind == IMA_K_PORT0) |=>
      (r.sect == 8'h00) && (r.offs == $past(r.ptr0));
  endproperty
  a_port0_sector0: assert property (p_port0_sector0)
    else $error("port zero left sector 0");

  property p_port1_sector;
    @(posedge clk) disable iff (!rstn || !ce)
    take && (dir_if.kind == IMA_K_PORT1) |=>
      (r.sect == $past(r.ptr1_sect)) && (r.offs == $past(r.ptr1_lo));
  endproperty
  a_port1_sector: assert property (p_port1_sector) else $error("port one sector wrong");

  property p_port_target_read;
    @(posedge clk) disable iff (!rstn || !ce)
    take && !cpu_we && ima_is_port(res_if.kind) |-> ##2 cpu_ack && (cpu_rdata == 8'h00);
  endproperty
  a_port_target_read: assert property (p_port_target_read) else $error("port target read");

  property p_port_target_write;
    @(posedge clk) disable iff (!rstn || !ce)
    take && cpu_we && ima_is_port(res_if.kind) |->
      ##1 (!ram_req && !sfr_req) ##1 (ptrs == $past(ptrs, 2));
  endproperty
  a_port_target_write: assert property (p_port_target_write)
    else $error("port write acted");

  property p_ram_upper_half;
    @(posedge clk) disable iff (!rstn || !ce)
    ram_req |-> r.offs[7] && !sfr_req;
  endproperty
  a_ram_upper_half: assert property (p_ram_upper_half)
    else $error("low half sent to ram");

  property p_ptr0_write;
    @(posedge clk) disable iff (!rstn || !ce)
    take && cpu_we && (res_if.kind == IMA_K_PTR) && (res_offs == 8'h01) |->
      ##2 (r.ptr0 == $past(cpu_wdata, 2));
  endproperty
  a_ptr0_write: assert property (p_ptr0_write) else $error("pointer_zero not written");

  // cross-check of the write strobe against the masks, independent of the kind decode
  property p_locked_no_write;
    @(posedge clk) disable iff (!rstn || !ce)
    sfr_we |-> !locked_mask[r.offs[6:0]];
  endproperty
  a_locked_no_write: assert property (p_locked_no_write)
    else $error("write reached a locked register");

  c_port1_ram: cover property (@(posedge clk) take && (dir_if.kind == IMA_K_PORT1) &&
                               (res_if.kind == IMA_K_RAM));
  c_port0_sfr: cover property (@(posedge clk) take && (dir_if.kind == IMA_K_PORT0) &&
                               (res_if.kind == IMA_K_SFR));
  c_port_loop: cover property (@(posedge clk) take && ima_is_port(res_if.kind));
  c_ptr_write: cover property (@(posedge clk) take && cpu_we && (res_if.kind == IMA_K_PTR));

endmodule : ima_indirect_top
`default_nettype wire

// ### sim/ima_mem_model.sv
// model: general RAM and special-purpose registers behind the indirect access block
`timescale 1ns/1ps
`default_nettype none
module ima_mem_model
(
  input  wire logic        clk,
  input  wire logic        ram_req,
  input  wire logic        ram_we,
  input  wire logic [10:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  output logic [7:0]       ram_rdata,
  input  wire logic        sfr_req,
  input  wire logic        sfr_we,
  input  wire logic [11:0] sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata
);
  logic [7:0] ram_mem [0:2047];
  logic [7:0] sfr_mem [0:4095];
  logic [7:0] ram_last;
  logic [7:0] sfr_last;
  int         wr_cnt;

  // ****************************************************************
  // storage
  // ****************************************************************
  // nonzero fill except where the low address byte is c3h (sfr) or 3ah (ram), so a forced 00h read cannot pass by luck elsewhere
  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      sfr_mem[i] = 8'hc3 ^ i[7:0];
      if (i < 2048)
        ram_mem[i] = 8'h3a ^ i[7:0];
    end
    ram_last = 8'h00;
    sfr_last = 8'h00;
    wr_cnt   = 0;
  end

  // unselected data lines show the inverse of the last value, never a stale copy
  assign ram_rdata = ram_req ? ram_mem[ram_addr] : ~ram_last;
  assign sfr_rdata = sfr_req ? sfr_mem[sfr_addr] : ~sfr_last;

  // writes land at the edge that ends the strobe cycle
  always @(posedge clk)
  begin
    if (ram_req)
    begin
      ram_last <= ram_rdata;
      if (ram_we)
      begin
        ram_mem[ram_addr] <= ram_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
    if (sfr_req)
    begin
      sfr_last <= sfr_rdata;
      if (sfr_we)
      begin
        sfr_mem[sfr_addr] <= sfr_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
endmodule : ima_mem_model
`default_nettype wire

// ### sim/ima_indirect_top_test.sv
// testbench: cpu-side access sequences against the indirect access block
`timescale 1ns/1ps
`default_nettype none
module ima_indirect_top_test;
  import ima_pkg::*;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        cpu_req;
  logic        cpu_we;
  logic [11:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        cpu_ready;
  logic        cpu_ack;
  logic [7:0]  cpu_rdata;
  logic        ram_req;
  logic        ram_we;
  logic [10:0] ram_addr;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  logic        sfr_req;
  logic        sfr_we;
  logic [11:0] sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  int          mismatches;
  int          checks;
  int          n;
  logic [7:0]  got;
  logic [7:0]  ptr_ofs [5] = '{IMA_OFS_PTR0, IMA_OFS_PTR1L, IMA_OFS_PTR1H,
                               IMA_OFS_PTR2L, IMA_OFS_PTR2H};
  logic [7:0]  ptr_val [5] = '{8'h85, 8'h85, 8'h01, 8'hff, 8'h0f};

  ima_indirect_top ima_indirect_top_i (.clk(clk), .rstn(rstn), .ce(ce), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .ram_req(ram_req), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .sfr_req(sfr_req),
    .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  ima_mem_model ima_mem_model_i (.clk(clk), .ram_req(ram_req), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .sfr_req(sfr_req),
    .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  // ****************************************************************
  // clock and reporting
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ****************************************************************
  // cpu access: request held from a falling edge until taken, then wait for ack
  // ****************************************************************
  task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(negedge clk);
    while (cpu_ready !== 1'b1 && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    cpu_req   = 1'b1;
    cpu_we    = we;
    cpu_addr  = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_req = 1'b0;
    // ack is a one-cycle pulse, so it is looked for at every falling edge
    while (cpu_ack !== 1'b1 && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    got = cpu_rdata;
    if (i >= 20)
    begin
      mismatches++;
      end_of_test();
    end
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk({24'h0, got}, {24'h0, exp});
  endtask : rd

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    mismatches = 0;
    checks     = 0;
    ce         = 1'b1;
    rstn       = 1'b0;
    cpu_req    = 1'b0;
    cpu_we     = 1'b0;
    cpu_addr   = 12'h000;
    cpu_wdata  = 8'h00;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    // pointers as plain registers: reset value, then write and read back
    for (n = 0; n < 5; n++)
      rd({4'h0, ptr_ofs[n]}, IMA_PTR_RST);
    for (n = 0; n < 5; n++)
      wr({4'h0, ptr_ofs[n]}, ptr_val[n]);
    for (n = 0; n < 5; n++)
      rd({4'h0, ptr_ofs[n]}, ptr_val[n]);
    // port zero lands in sector 0 general RAM
    wr({4'h0, IMA_OFS_PORT0}, 8'ha5);
    chk({24'h0, ima_mem_model_i.ram_mem[11'h005]}, 32'h0000_00a5);
    rd(12'h085, 8'ha5);
    // port one follows its sector byte, sector 0 copy untouched
    wr({4'h0, IMA_OFS_PORT1}, 8'h3c);
    chk({24'h0, ima_mem_model_i.ram_mem[11'h085]}, 32'h0000_003c);
    rd(12'h185, 8'h3c);
    rd(12'h085, 8'ha5);
    // port two at the top corner of the last sector
    wr({4'h0, IMA_OFS_PORT2}, 8'h96);
    rd(12'hfff, 8'h96);
    rd({4'h0, IMA_OFS_PORT2}, 8'h96);
    // port zero aimed into the special-purpose area
    wr({4'h0, IMA_OFS_PTR0}, 8'h10);
    wr({4'h0, IMA_OFS_PORT0}, 8'h77);
    chk({24'h0, ima_mem_model_i.sfr_mem[12'h010]}, 32'h0000_0077);
    rd({4'h0, IMA_OFS_PORT0}, 8'h77);
    // unused places read as zero, even after a write
    rd(12'h027, IMA_ZERO_DATA);
    rd(12'h17f, IMA_ZERO_DATA);
    wr(12'h038, 8'hff);
    rd(12'h038, IMA_ZERO_DATA);
    // a pointer that names a port: zero on read, nothing changes on write
    wr({4'h0, IMA_OFS_PTR0}, IMA_OFS_PORT2);
    rd({4'h0, IMA_OFS_PORT0}, IMA_ZERO_DATA);
    n = ima_mem_model_i.wr_cnt;
    wr({4'h0, IMA_OFS_PORT0}, 8'hee);
    chk(ima_mem_model_i.wr_cnt, n);
    rd({4'h0, IMA_OFS_PTR2L}, 8'hff);
    rd({4'h0, IMA_OFS_PTR0}, IMA_OFS_PORT2);
    // a sector byte beyond the last sector resolves to unused space
    wr({4'h0, IMA_OFS_PTR1H}, 8'(IMA_NUM_SECT));
    rd({4'h0, IMA_OFS_PORT1}, IMA_ZERO_DATA);
    wr({4'h0, IMA_OFS_PTR1H}, IMA_SECT_ZERO);
    wr({4'h0, IMA_OFS_PTR1L}, IMA_OFS_PORT0);
    rd({4'h0, IMA_OFS_PORT1}, IMA_ZERO_DATA);
    // reset in mid-run puts the pointers back to their reset value
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd({4'h0, IMA_OFS_PTR0}, IMA_PTR_RST);
    rd({4'h0, IMA_OFS_PTR2L}, IMA_PTR_RST);
    end_of_test();
  end
endmodule : ima_indirect_top_test
`default_nettype wire
